// *** hdl/connector_function_line_routing.v ***
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "line_routing_consts.vh"

module connector_function_line_routing (
   input wire CLK,
   input wire RSTN,
   // AXI4-Lite slave
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [3:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // General digital lines
   // Output enables are high where the board drives the pin
   input wire [7:0] GENERAL_DIGITAL_LINES_I,
   output reg [7:0] GENERAL_DIGITAL_LINES_O,
   output reg [7:0] GENERAL_DIGITAL_LINES_OE,
   // Strobe
   output reg EXTERNAL_STROBE_OUT,
   // Function lines 0..3
   // Lines 0, 1 and 3 drive out their selected internal signal; line 2 the sample clock
   input wire [3:0] FUNCTION_LINES_I,
   output reg [3:0] FUNCTION_LINES_O,
   output reg [3:0] FUNCTION_LINES_OE,
   // Internal timing and counter side
   // Same-clock levels, so no synchroniser is needed
   input wire ACQ_START_INTERNAL,
   input wire ACQ_REF_INTERNAL,
   input wire ACQUISITION_SAMPLE_CLOCK,
   input wire COUNTER_ONE_SRC_INTERNAL,
   output reg ACQUISITION_START_TRIGGER,
   output reg ACQUISITION_REFERENCE_TRIGGER,
   output reg COUNTER_ONE_SOURCE,
   output reg ANALOG_TRIGGER_SOURCE,
   output reg COUNTER_ZERO_UP,
   output reg COUNTER_ONE_UP
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   // A raw release could reach the flops on different edges
   reg rst_s1; // First reset stage
   reg rst_n; // Released reset

   // Two stage release of the asynchronous reset
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [7:0] dio_s1; // First stage, digital lines
   reg [7:0] dio_s2; // Usable digital lines
   reg [3:0] pfi_s1; // First stage, function lines
   reg [3:0] pfi_s2; // Usable function lines

   // Two flip-flops on every pin input
   // Only the second stage is read, to contain metastability
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         dio_s1 <= `BYTE_RESET;
         dio_s2 <= `BYTE_RESET;
         pfi_s1 <= 4'h0;
         pfi_s2 <= 4'h0;
      end else begin
         dio_s1 <= GENERAL_DIGITAL_LINES_I;
         dio_s2 <= dio_s1;
         pfi_s1 <= FUNCTION_LINES_I;
         pfi_s2 <= pfi_s1;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] dio_dir; // One direction bit per line
   reg [7:0] dio_out; // Output values
   reg [15:0] pfi_ctrl; // Function line control
   reg strobe_lvl; // Strobe level
   reg aw_hold; // Write address taken
   reg w_hold; // Write data taken
   reg [3:0] aw_addr; // Latched write address
   reg [31:0] w_data; // Latched write data
   reg [3:0] w_strb; // Latched strobes

   // Control fields decoded from the control word
   wire [3:0] pfi_dir = pfi_ctrl[`PFI_DIR_MSB:`PFI_DIR_LSB];
   wire [1:0] start_sel = pfi_ctrl[`START_SEL_MSB:`START_SEL_LSB];
   wire [1:0] ref_sel = pfi_ctrl[`REF_SEL_MSB:`REF_SEL_LSB];
   wire [1:0] csrc_sel = pfi_ctrl[`CSRC_SEL_MSB:`CSRC_SEL_LSB];
   // A write lands once both halves are held and no response waits
   wire do_write = aw_hold && w_hold && !S_AXI_BVALID;

   // Merge written bytes into an old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] strb;
      integer k;
      begin
         // Only bytes with their strobe set are replaced
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = din[k*8 +: 8];
            end
         end
      end
   endfunction

   // Pick a trigger source from line, software or internal logic
   function pick;
      input [1:0] sel;
      input line_ok;
      input line;
      input sw_level;
      input internal;
      begin
         // Unknown selections give a quiet low level
         case (sel)
            `SEL_LINE: pick = line_ok & line;
            `SEL_SOFT: pick = sw_level;
            `SEL_INTERNAL: pick = internal;
            default: pick = 1'b0;
         endcase
      end
   endfunction

   // Byte-merged candidates for each writable register
   wire [31:0] m_dir = merge({24'h0, dio_dir}, w_data, w_strb);
   wire [31:0] m_out = merge({24'h0, dio_out}, w_data, w_strb);
   wire [31:0] m_ctl = merge({16'h0, pfi_ctrl}, w_data, w_strb);

   // Write channel: address and data in either order, then response
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         // Everything idles low out of reset
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= `CTRL_RESET;
         w_strb <= 4'h0;
         dio_dir <= `BYTE_RESET;
         dio_out <= `BYTE_RESET;
         pfi_ctrl <= 16'h0000;
         strobe_lvl <= 1'b0;
      end else begin
         // Ready pulses one cycle and stays low while a half is held
         S_AXI_AWREADY <= !aw_hold && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY <= !w_hold && !S_AXI_WREADY && S_AXI_WVALID;
         // Address handshake latches the target word
         if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            aw_hold <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         // Data handshake latches data and byte strobes
         if (S_AXI_WREADY && S_AXI_WVALID) begin
            w_hold <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         // Response taken by the master
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         // Apply the held write and raise the response
         if (do_write) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= `RESP_OKAY;
            case (aw_addr)
               `OFS_DIO_DIR: dio_dir <= m_dir[7:0]; // [R1]
               `OFS_DIO_OUT: dio_out <= m_out[7:0];
               `OFS_DIO_IN: ; // Read only, ignored
               `OFS_PFI_CTRL: begin
                  pfi_ctrl <= m_ctl[15:0]; // [R13]
                  // Writing one to the strobe bit flips the pin
                  if (w_strb[`STROBE_BIT / 8] && w_data[`STROBE_BIT]) begin
                     strobe_lvl <= !strobe_lvl; // [R3]
                  end
               end
               default: S_AXI_BRESP <= `RESP_SLVERR;
            endcase
         end
      end
   end

   // Read channel: one cycle to accept, data on the next
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= `CTRL_RESET;
         S_AXI_RRESP <= `RESP_OKAY;
      end else begin
         // Ready pulses once per request, never while data waits
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `RESP_OKAY;
            S_AXI_RDATA <= `CTRL_RESET;
            // Unmapped words answer with an error and zero data
            case (S_AXI_ARADDR)
               `OFS_DIO_DIR: S_AXI_RDATA[7:0] <= dio_dir;
               `OFS_DIO_OUT: S_AXI_RDATA[7:0] <= dio_out;
               `OFS_DIO_IN: S_AXI_RDATA[7:0] <= dio_s2; // [R1]
               `OFS_PFI_CTRL: begin
                  S_AXI_RDATA[15:0] <= pfi_ctrl & ~(16'h0001 << `STROBE_BIT);
                  // Input lines read back; output lines read zero
                  S_AXI_RDATA[`PFI_IN_MSB:`PFI_IN_LSB] <=
                     pfi_s2 & ~pfi_dir; // [R12]
                  S_AXI_RDATA[`STROBE_LVL_BIT] <= strobe_lvl;
               end
               default: S_AXI_RRESP <= `RESP_SLVERR;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Routing
   // ----------------------------------------
   reg next_start; // Selected start trigger
   reg next_ref; // Selected reference trigger
   reg next_csrc; // Selected counter one source

   // Source selection; an output line never acts as a source
   always @* begin
      // Software choice reads as a constant low level
      next_start = pick(start_sel, !pfi_dir[0], pfi_s2[0],
         1'b0, ACQ_START_INTERNAL); // [R5] [R13]
      next_ref = pick(ref_sel, !pfi_dir[1], pfi_s2[1],
         1'b0, ACQ_REF_INTERNAL); // [R7] [R13]
      next_csrc = pick(csrc_sel, !pfi_dir[3], pfi_s2[3],
         1'b0, COUNTER_ONE_SRC_INTERNAL); // [R10] [R13]
   end

   // Registered pin and internal outputs
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         GENERAL_DIGITAL_LINES_O <= `BYTE_RESET;
         GENERAL_DIGITAL_LINES_OE <= `BYTE_RESET;
         EXTERNAL_STROBE_OUT <= 1'b0;
         FUNCTION_LINES_O <= 4'h0;
         FUNCTION_LINES_OE <= 4'h0;
         ACQUISITION_START_TRIGGER <= 1'b0;
         ACQUISITION_REFERENCE_TRIGGER <= 1'b0;
         COUNTER_ONE_SOURCE <= 1'b0;
         ANALOG_TRIGGER_SOURCE <= 1'b0;
         COUNTER_ZERO_UP <= 1'b0;
         COUNTER_ONE_UP <= 1'b0;
      end else begin
         // Directions and levels follow the registers a cycle later
         GENERAL_DIGITAL_LINES_OE <= dio_dir; // [R1]
         GENERAL_DIGITAL_LINES_O <= dio_out;
         EXTERNAL_STROBE_OUT <= strobe_lvl; // [R3]
         FUNCTION_LINES_OE <= pfi_dir; // [R13]
         // Function pins 0, 1 and 3 carry the signal that is really selected; pin 2 the sample clock
         FUNCTION_LINES_O[0] <= next_start; // [R6]
         FUNCTION_LINES_O[1] <= next_ref; // [R8]
         FUNCTION_LINES_O[2] <= ACQUISITION_SAMPLE_CLOCK; // [R9]
         FUNCTION_LINES_O[3] <= next_csrc; // [R11]
         // Internal consumers see the same selection as the pins
         ACQUISITION_START_TRIGGER <= next_start;
         ACQUISITION_REFERENCE_TRIGGER <= next_ref;
         COUNTER_ONE_SOURCE <= next_csrc;
         // Analog trigger path fed from input line zero
         ANALOG_TRIGGER_SOURCE <= pfi_ctrl[`ANA_TRIG_BIT] &&
            !pfi_dir[0] && pfi_s2[0]; // [R4]
         // Count direction from lines six and seven when enabled
         COUNTER_ZERO_UP <= pfi_ctrl[`UPDN0_EN_BIT] & dio_s2[6]; // [R2]
         COUNTER_ONE_UP <= pfi_ctrl[`UPDN1_EN_BIT] & dio_s2[7]; // [R2]
      end
   end

endmodule

// *** hdl/line_routing_consts.vh ***
// Contract
// [R1] Each digital line has its own direction
// [R2] Lines six, seven steer counter count direction
// [R3] Strobe is output only, toggles on request
// [R4] Line zero input: digital input, analog trigger
// [R5] Start trigger defaults to line zero
// [R6] Line zero output drives start trigger
// [R7] Reference trigger defaults to line one
// [R8] Line one output drives reference trigger
// [R9] Line two output mirrors sample clock
// [R10] Counter one source defaults to line three
// [R11] Line three output drives selected counter source
// [R12] Input function lines readable as general inputs
// [R13] Function line direction select; output blocks trigger
`ifndef LINE_ROUTING_CONSTS_VH
`define LINE_ROUTING_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_DIO_DIR 4'h0
`define OFS_DIO_OUT 4'h4
`define OFS_DIO_IN 4'h8
`define OFS_PFI_CTRL 4'hc

// ----------------------------------------
// Function line control fields
// ----------------------------------------
`define PFI_DIR_LSB 0
`define PFI_DIR_MSB 3
`define START_SEL_LSB 4
`define START_SEL_MSB 5
`define REF_SEL_LSB 6
`define REF_SEL_MSB 7
`define CSRC_SEL_LSB 8
`define CSRC_SEL_MSB 9
`define ANA_TRIG_BIT 10
`define UPDN0_EN_BIT 11
`define UPDN1_EN_BIT 12
`define STROBE_BIT 13
`define PFI_IN_LSB 16
`define PFI_IN_MSB 19
`define STROBE_LVL_BIT 20

// ----------------------------------------
// Source selections and reset values
// ----------------------------------------
`define SEL_LINE 2'h0
`define SEL_SOFT 2'h1
`define SEL_INTERNAL 2'h2
`define CTRL_RESET 32'h00000000
`define BYTE_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** tb/line_routing_checker.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checks of the connector routing
// ----------------------------------------
module line_routing_checker (
   input wire CLK,
   input wire RSTN,
   input wire S_AXI_BVALID,
   input wire S_AXI_ARREADY,
   input wire S_AXI_RVALID,
   input wire [7:0] GENERAL_DIGITAL_LINES_OE,
   input wire EXTERNAL_STROBE_OUT,
   input wire [3:0] FUNCTION_LINES_OE,
   input wire [3:0] FUNCTION_LINES_O,
   input wire [3:0] FUNCTION_LINES_I,
   input wire ANALOG_TRIGGER_SOURCE,
   input wire ACQUISITION_SAMPLE_CLOCK,
   input wire ACQUISITION_START_TRIGGER,
   input wire ACQUISITION_REFERENCE_TRIGGER,
   input wire COUNTER_ONE_SOURCE
);
   reg [2:0] up_edges; // Edges since release, saturating
   wire live; // Synced reset has surely let go
   assign live = up_edges == 3'h4;
   // Count edges so the mirror check skips the reset sync flops
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         up_edges <= 3'h0;
      end else if (!live) begin
         up_edges <= up_edges + 3'h1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   dio_dir_hold_a:
      assert property ($changed(GENERAL_DIGITAL_LINES_OE)
      |-> S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("dir moved");
   strobe_hold_a:
      assert property ($changed(EXTERNAL_STROBE_OUT)
      |-> S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("strobe moved");
   line_dir_hold_a:
      assert property ($changed(FUNCTION_LINES_OE)
      |-> S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("oe moved");
   start_pin_a:
      assert property (FUNCTION_LINES_O[0] == ACQUISITION_START_TRIGGER)
      else $error("start pin differs");
   ref_pin_a:
      assert property (FUNCTION_LINES_O[1] == ACQUISITION_REFERENCE_TRIGGER)
      else $error("ref pin differs");
   source_pin_a:
      assert property (FUNCTION_LINES_O[3] == COUNTER_ONE_SOURCE)
      else $error("source pin differs");
   sample_mirror_a:
      assert property (live |-> FUNCTION_LINES_O[2] ==
      $past(ACQUISITION_SAMPLE_CLOCK)) else $error("sample pin differs");
   read_answer_a:
      assert property (S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   analog_input_a:
      assert property (ANALOG_TRIGGER_SOURCE |-> !FUNCTION_LINES_OE[0] &&
      $past(FUNCTION_LINES_I[0], 3)) else $error("analog source wrong");
endmodule

bind connector_function_line_routing line_routing_checker watch (
   .CLK(CLK), .RSTN(RSTN), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .GENERAL_DIGITAL_LINES_OE(GENERAL_DIGITAL_LINES_OE),
   .EXTERNAL_STROBE_OUT(EXTERNAL_STROBE_OUT),
   .FUNCTION_LINES_OE(FUNCTION_LINES_OE),
   .FUNCTION_LINES_O(FUNCTION_LINES_O),
   .FUNCTION_LINES_I(FUNCTION_LINES_I),
   .ANALOG_TRIGGER_SOURCE(ANALOG_TRIGGER_SOURCE),
   .ACQUISITION_SAMPLE_CLOCK(ACQUISITION_SAMPLE_CLOCK),
   .ACQUISITION_START_TRIGGER(ACQUISITION_START_TRIGGER),
   .ACQUISITION_REFERENCE_TRIGGER(ACQUISITION_REFERENCE_TRIGGER),
   .COUNTER_ONE_SOURCE(COUNTER_ONE_SOURCE)
);

// *** tb/connector_equipment.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Equipment wired to the connector
// ----------------------------------------
module connector_equipment (
   input wire [7:0] dio_o,
   input wire [7:0] dio_oe,
   input wire [7:0] dio_drive,
   input wire [3:0] fl_o,
   input wire [3:0] fl_oe,
   input wire [3:0] fl_drive,
   output wire [7:0] dio_pin,
   output wire [3:0] fl_pin
);
   // A pin the board drives shows its level, else the equipment's
   assign dio_pin = (dio_oe & dio_o) | (~dio_oe & dio_drive);
   // Function pins: the board wins while it drives them
   assign fl_pin = (fl_oe & fl_o) | (~fl_oe & fl_drive);
endmodule

// *** tb/tb_connector_function_line_routing.sv ***
`timescale 1ns/1ps
module tb_connector_function_line_routing;
   reg clk = 1'h0, rstn = 1'h0, rdy = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0;
   reg [3:0] awaddr = 4'h0, araddr = 4'h0, strb = 4'hf;
   reg [31:0] wdata = 32'h0;
   reg [7:0] ext_dio = 8'h00; // Equipment levels on the digital lines
   reg [3:0] ext_fl = 4'h0, intl = 4'h0; // Function pins, internal sources
   wire awr, wr_r, bv, arr, rv, strobe, st, rt, cs, an, u0, u1;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [7:0] dio_i, dio_o, dio_oe;
   wire [3:0] fl_i, fl_o, fl_oe;
   integer failures = 0, samples_checked = 0, cycles = 0, i;
   reg [63:0] row;
   reg [63:0] rows [0:3]; // dir out ext ctrl fl int, expected routing
   connector_function_line_routing DUT (
      .CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(rdy), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
      .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rdy),
      .GENERAL_DIGITAL_LINES_I(dio_i), .GENERAL_DIGITAL_LINES_O(dio_o),
      .GENERAL_DIGITAL_LINES_OE(dio_oe), .EXTERNAL_STROBE_OUT(strobe),
      .FUNCTION_LINES_I(fl_i), .FUNCTION_LINES_O(fl_o),
      .FUNCTION_LINES_OE(fl_oe), .ACQ_START_INTERNAL(intl[3]),
      .ACQ_REF_INTERNAL(intl[2]), .ACQUISITION_SAMPLE_CLOCK(intl[1]),
      .COUNTER_ONE_SRC_INTERNAL(intl[0]), .ACQUISITION_START_TRIGGER(st),
      .ACQUISITION_REFERENCE_TRIGGER(rt), .COUNTER_ONE_SOURCE(cs),
      .ANALOG_TRIGGER_SOURCE(an), .COUNTER_ZERO_UP(u0), .COUNTER_ONE_UP(u1)
   );
   connector_equipment far (
      .dio_o(dio_o), .dio_oe(dio_oe), .dio_drive(ext_dio), .fl_o(fl_o),
      .fl_oe(fl_oe), .fl_drive(ext_fl), .dio_pin(dio_i), .fl_pin(fl_i)
   );
   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task chk(input [255:0] name, input [31:0] exp, input [31:0] seen);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("BAD %0s exp %h seen %h", name, exp, seen);
         end
      end
   endtask
   // Write one word; both channels offered together
   task wr(input [3:0] a, input [31:0] d);
      begin
         awaddr <= a;
         wdata <= d;
         awv <= 1'h1;
         wv <= 1'h1;
         do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wr_r) wv <= 1'h0;
         end while (!bv);
         chk("bresp", 2'h0, br);
      end
   endtask
   // Read one word; unaligned offsets are unmapped
   task rdchk(input [3:0] a, input [31:0] exp);
      begin
         araddr <= a;
         arv <= 1'h1;
         do begin
            @(posedge clk);
            if (arr) arv <= 1'h0;
         end while (!rv);
         chk("rresp", {|a[1:0], 1'h0}, rr);
         chk("rdata", exp, rdat);
      end
   endtask
   task print_verdict;
      begin
         $display("checked %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   // Free-running clock and a hang limit
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures = failures + 1;
         print_verdict;
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rows[0] = 64'h0000401c00b0003e;
      rows[1] = 64'hffa55a00012f0010;
      rows[2] = 64'h0f0cf002af0b0028;
      rows[3] = 64'h00ff801150ff0001;
      repeat (4) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 4; i = i + 1) rdchk({i[1:0], 2'h0}, 32'h0);
      for (i = 0; i < 4; i = i + 1) begin
         row = rows[i];
         wr(4'h0, row[63:56]);
         wr(4'h4, row[55:48]);
         ext_dio <= row[47:40];
         ext_fl <= row[23:20];
         intl <= row[19:16];
         wr(4'hc, row[39:24]);
         repeat (6) @(posedge clk);
         chk("dio_oe", row[63:56], dio_oe);
         chk("dio_o", row[55:48], dio_o);
         chk("fl_oe", row[27:24], fl_oe);
         chk("route", row[5:0], {st, rt, cs, an, u0, u1});
         chk("fl_o", {row[3], row[17], row[4], row[5]}, fl_o);
         rdchk(4'h8, row[47:40] & ~row[63:56] |
            row[55:48] & row[63:56]);
         rdchk(4'hc, {12'h0, row[23:20] & ~row[27:24], row[39:24]});
      end
      ext_fl <= 4'h0;
      for (i = 1; i < 3; i = i + 1) begin
         wr(4'hc, 32'h2000);
         repeat (2) @(posedge clk);
         chk("strobe", i[0], strobe);
         rdchk(4'hc, {11'h0, i[0], 20'h0});
      end
      wr(4'h8, 32'hff);
      rdchk(4'h8, {24'h0, ext_dio});
      rdchk(4'h2, 32'h0);
      wr(4'h0, 32'hff);
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      chk("dio_oe_rst", 8'h00, dio_oe);
      rstn <= 1'h1;
      repeat (4) @(posedge clk);
      rdchk(4'h0, 32'h0);
      print_verdict;
   end
endmodule
